// ### inc/tcp_pkg.sv
// Function
// - each of two 16-bit compare values is checked against the counter per timer tick
// - compare values are software read/write, untouched by hardware, reset to 8000h
// - a match sets compare flag i and drives pin i to level i if enabled
// - compare pin latches are held low during reset
// - compare interrupt only with compare irq enable set and cpu mask clear
// - output enable clear leaves pin as plain I/O; match may still interrupt
// - flag clears after status read while set, then low byte access
// - high byte write inhibits compare until low byte is written
// - divide-by-2 matches at equal count, other rates at count plus one
// - force bit with output enable copies level to pin, no flag, no irq
// - force bits are ignored in one-pulse and pwm modes
// - one-pulse capture edge: capture, reload FFFCh, level 2 on pin 1, flag
// - one-pulse: match on compare 1 drives level 1 on pin 1
// - one-pulse: compare flag 1 never set, compare flag 2 still works
// - pwm and one-pulse both selected means pwm only
// - one-pulse: capture pin 1 not captured for software, capture 2 still works
// - one-pulse: channel 2 flags time only, no waveform on pin 2
// - equal levels give a constant level on pin 1
// - pwm: compare 2 is period, compare 1 pulse, shadows load at period end
// - pwm: high byte write blocks shadow transfer until low byte written
// - pwm: compare always enabled regardless of inhibit
// - pwm: match on compare 2 reloads counter to FFFCh
// - pwm: no compare flags; capture flag 1 set at period end
// - pwm: high pulse length equals compare 2 minus compare 1
package tcp_pkg;

  // ==========================================================================
  // register map (byte addresses, one byte per word)
  localparam logic [7:0] ADDR_CTRL_A  = 8'h00;
  localparam logic [7:0] ADDR_CTRL_B  = 8'h04;
  localparam logic [7:0] ADDR_STATUS  = 8'h08;
  localparam logic [7:0] ADDR_CMP1_HI = 8'h0C;
  localparam logic [7:0] ADDR_CMP1_LO = 8'h10;
  localparam logic [7:0] ADDR_CMP2_HI = 8'h14;
  localparam logic [7:0] ADDR_CMP2_LO = 8'h18;

  // ==========================================================================
  // timer_control_a fields
  localparam int CA_CAP_IE    = 7;
  localparam int CA_CMP_IE    = 6;
  localparam int CA_OVF_IE    = 5;
  localparam int CA_FORCE_2   = 4;
  localparam int CA_FORCE_1   = 3;
  localparam int CA_LEVEL_2   = 2;
  localparam int CA_CAP_EDGE1 = 1;
  localparam int CA_LEVEL_1   = 0;

  // timer_control_b fields
  localparam int CB_OE_1      = 7;
  localparam int CB_OE_2      = 6;
  localparam int CB_ONE_PULSE = 5;
  localparam int CB_PWM       = 4;
  localparam int CB_PRESC_HI  = 3;
  localparam int CB_PRESC_LO  = 2;

  // timer_status_reg fields
  localparam int ST_CAP_F1 = 7;
  localparam int ST_CMP_F1 = 6;
  localparam int ST_OVF    = 5;
  localparam int ST_CAP_F2 = 4;
  localparam int ST_CMP_F2 = 3;

  // ==========================================================================
  // reset values and encodings
  localparam logic [7:0]  CTRL_RST    = 8'h00;
  localparam logic [15:0] CMP_RST     = 16'h8000;
  localparam logic [1:0]  PRESC_DIV2  = 2'h1;
  localparam logic [1:0]  HTRANS_NSEQ = 2'h2;
  localparam logic        HRESP_OKAY  = 1'b0;

  // ==========================================================================
  typedef struct packed {
    logic        hsel;
    logic [1:0]  htrans;
    logic [7:0]  haddr;
    logic        hwrite;
    logic [2:0]  hsize;
    logic        hready;
    logic [31:0] hwdata;
  } ahb_req_t;

  typedef struct packed {
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
  } ahb_rsp_t;

  typedef struct packed {
    logic [15:0] counter;
    logic        tick;
    logic        cap_flag_1;
    logic        cap_flag_2;
    logic        ovf_flag;
    logic        cpu_irq_mask;
  } timer_in_t;

  typedef struct packed {
    logic counter_reload;
    logic capture_1_load;
    logic capture_1_set;
  } timer_out_t;

endpackage

// ### rtl/timer_compare_pulse_pwm.sv
`timescale 1ns/1ps
module timer_compare_pulse_pwm
  import tcp_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       arst_n_i,
  input  wire ahb_req_t   ahb_i,
  output ahb_rsp_t        ahb_o,
  input  wire timer_in_t  tmr_i,
  output timer_out_t      tmr_o,
  input  wire logic       capture_pin_1_i,
  output logic [1:0]      compare_out_pin_o,
  output logic [1:0]      compare_out_oe_o,
  output logic            irq_o
);

  // ==========================================================================
  // state
  typedef struct packed {
    logic [7:0]       ctrl_a;
    logic [7:0]       ctrl_b;
    logic [1:0][15:0] cmp;
    logic [1:0][15:0] shadow;
    logic [1:0]       inhibit;
    logic [1:0]       cflag;
    logic [1:0]       arm;
    logic [1:0]       pin;
    logic [1:0]       oe;
    logic             cap1_prev;
    logic             tick_q;
    logic             irq;
    timer_out_t       tout;
    logic             wr_pend;
    logic             rd_pend;
    logic [7:0]       addr;
    logic             hready;
    logic [31:0]      hrdata;
  } st_t;

  localparam st_t ST_RST = '{
    ctrl_a:    CTRL_RST,
    ctrl_b:    CTRL_RST,
    cmp:       {CMP_RST, CMP_RST},
    shadow:    {CMP_RST, CMP_RST},
    inhibit:   2'h0,
    cflag:     2'h0,
    arm:       2'h0,
    pin:       2'h0,
    oe:        2'h0,
    cap1_prev: 1'b0,
    tick_q:    1'b0,
    irq:       1'b0,
    tout:      '0,
    wr_pend:   1'b0,
    rd_pend:   1'b0,
    addr:      8'h00,
    hready:    1'b1,
    hrdata:    32'h0000_0000
  };

  st_t q;
  st_t d;

  logic        pwm_mode;
  logic        opm_mode;
  logic        div2;
  logic [1:0]  hit;
  logic [1:0]  cflag_set;
  logic [1:0]  lo_access;
  logic        cap1_edge;
  logic        accept;
  logic [7:0]  wbyte;
  logic [7:0]  rbyte;
  logic [15:0] ref_v;

  // ==========================================================================
  // combinational next state
  always_comb begin
    d         = q;
    cflag_set = 2'h0;
    lo_access = 2'h0;
    hit       = 2'h0;
    ref_v     = 16'h0000;
    rbyte     = 8'h00;
    wbyte     = ahb_i.hwdata[7:0];

    pwm_mode = q.ctrl_b[CB_PWM];
    opm_mode = q.ctrl_b[CB_ONE_PULSE] & ~q.ctrl_b[CB_PWM];
    div2     = q.ctrl_b[CB_PRESC_HI:CB_PRESC_LO] == PRESC_DIV2;

    d.tick_q = tmr_i.tick;
    d.tout   = '0;

    // counter has just advanced when tick_q is high
    for (int i = 0; i < 2; i++) begin
      ref_v = pwm_mode ? q.shadow[i] : q.cmp[i];
      if (q.tick_q) begin
        if (div2) begin
          hit[i] = tmr_i.counter == ref_v;
        end else begin
          hit[i] = tmr_i.counter == 16'(ref_v + 16'h0001);
        end
      end
      // compare inhibited after a high byte write outside pwm
      if (!pwm_mode && q.inhibit[i]) begin
        hit[i] = 1'b0;
      end
    end

    // ------------------------------------------------------------------------
    // capture pin 1 edge, only used in one-pulse mode
    d.cap1_prev = capture_pin_1_i;
    cap1_edge   = q.ctrl_a[CA_CAP_EDGE1] ?
                  (capture_pin_1_i & ~q.cap1_prev) :
                  (~capture_pin_1_i & q.cap1_prev);

    // ------------------------------------------------------------------------
    // waveform and flags per mode
    if (pwm_mode) begin
      if (hit[0] && q.oe[0]) begin
        d.pin[0] = q.ctrl_a[CA_LEVEL_1];
      end
      if (hit[1]) begin
        if (q.oe[0]) begin
          d.pin[0] = q.ctrl_a[CA_LEVEL_2];
        end
        d.tout.counter_reload = 1'b1;
        d.tout.capture_1_set  = 1'b1;
        for (int i = 0; i < 2; i++) begin
          if (!q.inhibit[i]) begin
            d.shadow[i] = q.cmp[i];
          end
        end
      end
    end else if (opm_mode) begin
      if (cap1_edge) begin
        d.tout.capture_1_load = 1'b1;
        d.tout.capture_1_set  = 1'b1;
        d.tout.counter_reload = 1'b1;
        if (q.oe[0]) begin
          d.pin[0] = q.ctrl_a[CA_LEVEL_2];
        end
      end else if (hit[0] && q.oe[0]) begin
        d.pin[0] = q.ctrl_a[CA_LEVEL_1];
      end
      cflag_set[1] = hit[1];
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (hit[i]) begin
          cflag_set[i] = 1'b1;
          if (q.oe[i]) begin
            d.pin[i] = i == 0 ? q.ctrl_a[CA_LEVEL_1] :
                                q.ctrl_a[CA_LEVEL_2];
          end
        end
      end
      // forced level, no flag set
      if (q.ctrl_a[CA_FORCE_1] && q.oe[0]) begin
        d.pin[0] = q.ctrl_a[CA_LEVEL_1];
      end
      if (q.ctrl_a[CA_FORCE_2] && q.oe[1]) begin
        d.pin[1] = q.ctrl_a[CA_LEVEL_2];
      end
    end

    // shadows follow the compare values outside pwm
    if (!pwm_mode) begin
      d.shadow = q.cmp;
    end

    // ------------------------------------------------------------------------
    // bus write, data phase
    if (q.wr_pend) begin
      if (q.addr == ADDR_CTRL_A) begin
        d.ctrl_a = wbyte;
      end else if (q.addr == ADDR_CTRL_B) begin
        d.ctrl_b = wbyte;
      end else if (q.addr == ADDR_CMP1_HI) begin
        d.cmp[0][15:8] = wbyte;
        d.inhibit[0]   = 1'b1;
      end else if (q.addr == ADDR_CMP1_LO) begin
        d.cmp[0][7:0]  = wbyte;
        d.inhibit[0]   = 1'b0;
        lo_access[0]   = 1'b1;
      end else if (q.addr == ADDR_CMP2_HI) begin
        d.cmp[1][15:8] = wbyte;
        d.inhibit[1]   = 1'b1;
      end else if (q.addr == ADDR_CMP2_LO) begin
        d.cmp[1][7:0]  = wbyte;
        d.inhibit[1]   = 1'b0;
        lo_access[1]   = 1'b1;
      end
    end

    // ------------------------------------------------------------------------
    // bus read, wait cycle after the address phase
    if (q.rd_pend) begin
      if (q.addr == ADDR_CTRL_A) begin
        rbyte = q.ctrl_a;
      end else if (q.addr == ADDR_CTRL_B) begin
        rbyte = q.ctrl_b;
      end else if (q.addr == ADDR_STATUS) begin
        rbyte[ST_CAP_F1] = tmr_i.cap_flag_1;
        rbyte[ST_CMP_F1] = q.cflag[0];
        rbyte[ST_OVF]    = tmr_i.ovf_flag;
        rbyte[ST_CAP_F2] = tmr_i.cap_flag_2;
        rbyte[ST_CMP_F2] = q.cflag[1];
        d.arm            = q.arm | q.cflag;
      end else if (q.addr == ADDR_CMP1_HI) begin
        rbyte = q.cmp[0][15:8];
      end else if (q.addr == ADDR_CMP1_LO) begin
        rbyte        = q.cmp[0][7:0];
        lo_access[0] = 1'b1;
      end else if (q.addr == ADDR_CMP2_HI) begin
        rbyte = q.cmp[1][15:8];
      end else if (q.addr == ADDR_CMP2_LO) begin
        rbyte        = q.cmp[1][7:0];
        lo_access[1] = 1'b1;
      end
      d.hrdata  = {24'h000000, rbyte};
      d.rd_pend = 1'b0;
      d.hready  = 1'b1;
    end

    // ------------------------------------------------------------------------
    // flag clear by armed low byte access, set wins
    for (int i = 0; i < 2; i++) begin
      if (lo_access[i] && q.arm[i]) begin
        d.cflag[i] = 1'b0;
        d.arm[i]   = 1'b0;
      end
      if (cflag_set[i]) begin
        d.cflag[i] = 1'b1;
      end
    end

    // ------------------------------------------------------------------------
    // address phase
    accept    = ahb_i.hsel && ahb_i.hready && ahb_i.htrans == HTRANS_NSEQ;
    d.wr_pend = 1'b0;
    if (accept) begin
      d.addr = ahb_i.haddr;
      if (ahb_i.hwrite) begin
        d.wr_pend = 1'b1;
      end else begin
        d.rd_pend = 1'b1;
        d.hready  = 1'b0;
      end
    end

    d.oe  = {q.ctrl_b[CB_OE_2], q.ctrl_b[CB_OE_1]};
    d.irq = q.ctrl_a[CA_CMP_IE] && !tmr_i.cpu_irq_mask &&
            (d.cflag != 2'h0);
  end

  // ==========================================================================
  // registers
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      q <= ST_RST;
    end else begin
      q <= d;
    end
  end

  // ==========================================================================
  // outputs
  assign ahb_o.hrdata      = q.hrdata;
  assign ahb_o.hreadyout   = q.hready;
  assign ahb_o.hresp       = HRESP_OKAY;
  assign tmr_o             = q.tout;
  assign compare_out_pin_o = q.pin;
  assign compare_out_oe_o  = q.oe;
  assign irq_o             = q.irq;

endmodule

// ### testbench/pin_partner.sv
`timescale 1ns/1ps
// ==========================================================
// pads with pull-ups and a capture pin driver
module pin_partner (
  input  wire logic       clk_i,
  input  wire logic       pulse_req_i,
  input  wire logic [1:0] pin_i,
  input  wire logic [1:0] oe_i,
  output logic            capture_pin_o,
  output logic [1:0]      pad_o
);
  logic [2:0] hold_q = 3'h0;
  // an undriven pad is pulled high
  assign pad_o = (pin_i & oe_i) | ~oe_i;
  always @(posedge clk_i) begin
    hold_q <= pulse_req_i ? 3'h7 : hold_q >> 1;
  end
  assign capture_pin_o = hold_q[0];
endmodule

// ### testbench/tcp_properties.sv
`timescale 1ns/1ps
// ==========================================================
// bus, pin and strobe properties
module tcp_properties
  import tcp_pkg::*;
(
  input wire logic       clk_i,
  input wire logic       arst_n_i,
  input wire ahb_req_t   ahb_i,
  input wire ahb_rsp_t   ahb_o,
  input wire timer_in_t  tmr_i,
  input wire timer_out_t tmr_o,
  input wire logic       capture_pin_1_i,
  input wire logic [1:0] compare_out_pin_o,
  input wire logic [1:0] compare_out_oe_o,
  input wire logic       irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  logic acc;
  logic wr_q;
  assign acc = ahb_i.hsel && ahb_i.hready && ahb_i.htrans == HTRANS_NSEQ;
  // marks the data phase of an accepted write
  always_ff @(posedge clk_i or negedge arst_n_i)
    if (!arst_n_i) wr_q <= 1'b0;
    else wr_q <= acc && ahb_i.hwrite;
  sequence s_rd;
    acc && !ahb_i.hwrite;
  endsequence
  sequence s_one_wait;
    !ahb_o.hreadyout ##1 ahb_o.hreadyout;
  endsequence
  a_read_one_wait: assert property (s_rd |=> s_one_wait)
    else $error("read wait state wrong");
  a_write_no_wait: assert property (acc && ahb_i.hwrite |=> ahb_o.hreadyout)
    else $error("write stalled");
  a_bus_okay: assert property (ahb_o.hresp == HRESP_OKAY && ahb_o.hrdata[31:8] == 24'h0)
    else $error("bad response or upper read data");
  a_pins_reset: assert property ($rose(arst_n_i) |-> compare_out_pin_o == 2'b00)
    else $error("compare pins not low from reset");
  a_irq_masked: assert property (irq_o |-> !$past(tmr_i.cpu_irq_mask))
    else $error("irq raised while masked");
  a_oe_by_write: assert property ($changed(compare_out_oe_o) |-> $past(wr_q) || $past(wr_q, 2))
    else $error("output enable moved without a write");
  a_reload_pulse: assert property (tmr_o.counter_reload |=> !tmr_o.counter_reload)
    else $error("reload strobe longer than one cycle");
  a_load_reloads: assert property (tmr_o.capture_1_load |-> tmr_o.counter_reload && tmr_o.capture_1_set)
    else $error("pulse start strobes apart");
  a_reload_sets: assert property (tmr_o.counter_reload |-> tmr_o.capture_1_set)
    else $error("reload without capture flag set");
endmodule
bind timer_compare_pulse_pwm tcp_properties u_tcp_properties (.clk_i,
  .arst_n_i, .ahb_i, .ahb_o, .tmr_i, .tmr_o, .capture_pin_1_i,
  .compare_out_pin_o, .compare_out_oe_o, .irq_o);

// ### testbench/test_timer_compare_pulse_pwm.sv
`timescale 1ns/1ps
module test_timer_compare_pulse_pwm import tcp_pkg::*;;
  logic       clk_i = 1'b0;
  logic       arst_n_i = 1'b0;
  ahb_req_t   req = '0;
  ahb_req_t   bus_w;
  ahb_rsp_t   rsp;
  timer_in_t  tmr = '0;
  timer_out_t tout;
  logic       cap_pin;
  logic       fire = 1'b0;
  logic       irq;
  logic [1:0] pins;
  logic [1:0] oe;
  logic [1:0] pad;
  logic [7:0] rd;
  int miscompares = 0, cmp_count = 0, cycles = 0;
  int n_rl = 0, n_ld = 0, n_st = 0, r0, l0, s0;
  always #4 clk_i = ~clk_i;
  always_comb begin
    bus_w = req;
    bus_w.hready = rsp.hreadyout;
  end
  timer_compare_pulse_pwm u_timer_compare_pulse_pwm (.clk_i, .arst_n_i,
    .ahb_i(bus_w), .ahb_o(rsp), .tmr_i(tmr), .tmr_o(tout),
    .capture_pin_1_i(cap_pin), .compare_out_pin_o(pins),
    .compare_out_oe_o(oe), .irq_o(irq));
  pin_partner u_pin_partner (.clk_i, .pulse_req_i(fire), .pin_i(pins),
    .oe_i(oe), .capture_pin_o(cap_pin), .pad_o(pad));
  // ==========================================================
  // strobe counters and hang guard
  always @(posedge clk_i) begin
    if (tout.counter_reload === 1'b1) n_rl++;
    if (tout.capture_1_load === 1'b1) n_ld++;
    if (tout.capture_1_set === 1'b1) n_st++;
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      finish_test();
    end
  end
  // ==========================================================
  // tasks
  task automatic finish_test();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [7:0] d);
    req.hsel <= 1'b1;
    req.htrans <= HTRANS_NSEQ;
    req.haddr <= a;
    req.hwrite <= w;
    req.hsize <= 3'h2;
    do @(posedge clk_i); while (rsp.hreadyout !== 1'b1);
    req.hsel <= 1'b0;
    req.htrans <= 2'h0;
    req.hwdata <= {24'h0, d};
    do @(posedge clk_i); while (rsp.hreadyout !== 1'b1);
    rd = rsp.hrdata[7:0];
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(rd, e);
  endtask
  task automatic setv(input logic [7:0] a, input logic [15:0] v);
    wr(a, v[15:8]);
    wr(a + 8'h04, v[7:0]);
  endtask
  // one counter step per tick, ticks three cycles apart
  task automatic adv(input int n);
    repeat (n) begin
      tmr.tick <= 1'b1;
      @(posedge clk_i);
      tmr.tick <= 1'b0;
      tmr.counter <= tmr.counter + 16'h0001;
      repeat (2) @(posedge clk_i);
    end
    repeat (2) @(posedge clk_i);
  endtask
  task automatic start_at(input logic [15:0] v);
    tmr.counter <= v;
    @(posedge clk_i);
  endtask
  // ==========================================================
  // tests
  initial begin
    repeat (10) @(posedge clk_i);
    chk(8'(pins), 8'h00);
    arst_n_i <= 1'b1;
    @(posedge clk_i);
    rc(ADDR_CMP1_HI, 8'h80);
    rc(ADDR_CMP1_LO, 8'h00);
    rc(ADDR_CMP2_HI, 8'h80);
    rc(ADDR_CMP2_LO, 8'h00);
    rc(8'h1C, 8'h00);
    wr(ADDR_CMP1_HI, 8'h5A);
    rc(ADDR_CMP1_HI, 8'h5A);
    $display("test reset done");
    wr(ADDR_CTRL_B, 8'h84);
    wr(ADDR_CTRL_A, 8'h45);
    setv(ADDR_CMP1_HI, 16'h0010);
    setv(ADDR_CMP2_HI, 16'h0012);
    start_at(16'h000F);
    adv(1);
    chk(8'({irq, pins}), 8'h05);
    adv(2);
    chk(8'({pad, oe}), 8'h0D);
    rc(ADDR_STATUS, 8'h48);
    tmr.cpu_irq_mask <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk(8'(irq), 8'h00);
    tmr.cpu_irq_mask <= 1'b0;
    rc(ADDR_CMP1_LO, 8'h10);
    rc(ADDR_STATUS, 8'h08);
    wr(ADDR_CMP2_LO, 8'h12);
    rc(ADDR_STATUS, 8'h00);
    $display("test compare done");
    wr(ADDR_CMP1_HI, 8'h00);
    start_at(16'h000F);
    adv(1);
    rc(ADDR_STATUS, 8'h00);
    wr(ADDR_CMP1_LO, 8'h10);
    start_at(16'h000F);
    adv(1);
    rc(ADDR_STATUS, 8'h40);
    wr(ADDR_CMP1_HI, 8'h00);
    rc(ADDR_STATUS, 8'h40);
    wr(ADDR_CMP1_LO, 8'h10);
    rc(ADDR_STATUS, 8'h00);
    $display("test inhibit done");
    wr(ADDR_CTRL_A, 8'h44);
    wr(ADDR_CTRL_B, 8'h88);
    start_at(16'h000F);
    adv(1);
    rc(ADDR_STATUS, 8'h00);
    adv(1);
    rc(ADDR_STATUS, 8'h40);
    chk(8'(pins), 8'h00);
    rc(ADDR_CMP1_LO, 8'h10);
    $display("test prescale done");
    wr(ADDR_CTRL_B, 8'h84);
    wr(ADDR_CTRL_A, 8'h49);
    repeat (3) @(posedge clk_i);
    chk(8'({irq, pins}), 8'h01);
    rc(ADDR_STATUS, 8'h00);
    wr(ADDR_CTRL_A, 8'h48);
    wr(ADDR_CTRL_B, 8'hA4);
    wr(ADDR_CTRL_A, 8'h09);
    repeat (3) @(posedge clk_i);
    chk(8'(pins), 8'h00);
    $display("test force done");
    wr(ADDR_CTRL_A, 8'h46);
    r0 = n_rl;
    l0 = n_ld;
    s0 = n_st;
    fire <= 1'b1;
    @(posedge clk_i);
    fire <= 1'b0;
    repeat (6) @(posedge clk_i);
    chk(8'((n_rl - r0) * 16 + (n_ld - l0) * 4 + n_st - s0), 8'h15);
    chk(8'(pins), 8'h01);
    start_at(16'h000F);
    adv(1);
    chk(8'(pins), 8'h00);
    adv(2);
    rc(ADDR_STATUS, 8'h08);
    chk(8'(irq), 8'h01);
    wr(ADDR_CTRL_A, 8'h42);
    l0 = n_ld;
    fire <= 1'b1;
    @(posedge clk_i);
    fire <= 1'b0;
    repeat (6) @(posedge clk_i);
    chk(8'(n_ld - l0), 8'h01);
    chk(8'(pins), 8'h00);
    wr(ADDR_CMP2_LO, 8'h12);
    $display("test one pulse done");
    wr(ADDR_CTRL_B, 8'hB4);
    wr(ADDR_CTRL_A, 8'h41);
    setv(ADDR_CMP2_HI, 16'h0030);
    r0 = n_rl;
    l0 = n_ld;
    start_at(16'h000F);
    adv(1);
    chk(8'(pins), 8'h01);
    adv(2);
    chk(8'({irq, pins}), 8'h00);
    chk(8'(n_rl - r0), 8'h01);
    rc(ADDR_STATUS, 8'h00);
    fire <= 1'b1;
    @(posedge clk_i);
    fire <= 1'b0;
    repeat (6) @(posedge clk_i);
    chk(8'(n_ld - l0), 8'h00);
    start_at(16'h002F);
    adv(1);
    chk(8'(n_rl - r0), 8'h02);
    wr(ADDR_CMP1_LO, 8'h20);
    wr(ADDR_CMP1_HI, 8'h00);
    start_at(16'h002F);
    adv(1);
    chk(8'({n_rl - r0, pins}), 8'h0C);
    start_at(16'h000F);
    adv(1);
    chk(8'(pins), 8'h01);
    $display("test pwm done");
    finish_test();
  end
endmodule
